/* rtcev_pkg.sv */
package rtcev_pkg;
   // Core clock and derived second period
   localparam int CLK_HZ = 25_000_000;
   localparam int SEC_PERIOD_S = 1;
   localparam int SEC_CYCLES = CLK_HZ * SEC_PERIOD_S;
   localparam int HOUR_S = 3600;
   localparam int MAX_UPDATES = 8;

   // Register indices, byte address is four times the index
   localparam logic [15:0] IDX_STAT = 16'h4011;
   localparam logic [15:0] IDX_MASK = 16'h4019;
   localparam logic [15:0] IDX_TAG = 16'h4020;
   localparam logic [15:0] IDX_TIME_HI = 16'h4021;
   localparam logic [15:0] IDX_TIME_LO = 16'h4022;
   localparam logic [15:0] IDX_ALM_HI = 16'h4023;
   localparam logic [15:0] IDX_ALM_LO = 16'h4024;
   localparam logic [15:0] IDX_CTRL = 16'h4025;
   localparam logic [15:0] IDX_BKUP = 16'h4030;
   localparam logic [15:0] IDX_SCRATCH = 16'h4031;

   // Field positions
   localparam int STAT_PER_BIT = 3;
   localparam int STAT_ALM_BIT = 2;
   localparam int CTRL_SEL_LSB = 4;
   localparam int CTRL_SEL_W = 3;
   localparam int CTRL_ALMENA_BIT = 10;
   localparam int CTRL_BUSY_BIT = 14;
   localparam int CTRL_VALID_BIT = 15;
   localparam int BKUP_KEEP_BIT = 0;

   // Reset values
   localparam logic [15:0] TAG_RST = 16'h0000;
   localparam logic [15:0] SCRATCH_RST = 16'h0000;
   localparam logic [31:0] TIME_RST = 32'h0000_0000;
   localparam logic MASK_BIT_RST = 1'b1;
   localparam logic KEEP_RST = 1'b1;
   localparam logic [CTRL_SEL_W-1:0] SEL_RST = 3'h0;
   // Arbitrary nonzero seed for the random tag source
   localparam logic [15:0] TAG_SEED = 16'hace1;
   localparam logic [15:0] TAG_TAPS = 16'hb400;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic per;
      logic alm;
   } rtcev_evt_t;

   typedef struct packed {
      logic valid;
      logic alm_ena;
      logic [CTRL_SEL_W-1:0] sel;
   } rtcev_ctrl_t;
endpackage

/* rtcev_tag_gen.sv */
`timescale 1ns/100ps
module rtcev_tag_gen #(
   parameter int W = 16,
   parameter logic [W-1:0] SEED = rtcev_pkg::TAG_SEED,
   parameter logic [W-1:0] TAPS = rtcev_pkg::TAG_TAPS
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic clk_en,
   // Tag candidate
   input wire logic [W-1:0] cur_tag,
   output logic [W-1:0] tag_new
);
   import rtcev_pkg::*;

   logic [W-1:0] lfsr_r;
   logic [W-1:0] lfsr_nxt;

   generate
      if (W < 2 || SEED == '0)
      begin : g_bad
         $error("tag width below 2 or zero seed");
      end
   endgenerate

   // Free-running, so the value taken depends on write timing
   always_comb
   begin
      lfsr_nxt = lfsr_r;
      if (clk_en)
      begin
         lfsr_nxt = {1'b0, lfsr_r[W-1:1]} ^ (lfsr_r[0] ? TAPS : '0);
      end
   end

   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
         lfsr_r <= SEED;
      else
         lfsr_r <= lfsr_nxt;
   end

   assign tag_new = (lfsr_r == cur_tag) ? ~lfsr_r : lfsr_r;
endmodule

/* rtcev_core.sv */
// Overview of operation
// - Periodic flag sets each time the selected interval elapses.
// - Alarm flag sets when the alarm condition fires.
// - Either unmasked flag drives the primary clock interrupt.
// - Periodic flag is status bit 3, alarm bit 2, rising-edge set.
// - Writing one clears a flag, zero leaves it.
// - Mask bits 3 and 2 gate flags; one masks; reset to one.
// - Interval code 0 disables; codes 1..7 give 2s to 128s.
// - Interval field is control bits 6:4, reset zero.
// - Write tag resets to zero.
// - Write tag updates on every accepted write to either counter half.
// - New tag is random, tag itself not writable.
// - At most eight counter updates per hour, extras silently ignored.
// - Backup resets flags, masks, interval and alarm enable; keeps counter, oscillator, scratch.
// - Keep bit zero stops the clock in backup; counter held.
// - 32-bit seconds counter increments once per second.
// - Enabled alarm fires when counter equals alarm time.
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module rtcev_core #(
   parameter int SEC_CYCLES = rtcev_pkg::SEC_CYCLES
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic clk_en,
   // AXI4-Lite write
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Power state pin and interrupt
   input wire logic backup_mode,
   output logic rtc_irq,
   output rtcev_pkg::rtcev_evt_t evt_flags
);
   import rtcev_pkg::*;

   localparam int DIV_W = $clog2(SEC_CYCLES);
   localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SEC_CYCLES - 1);
   localparam logic [11:0] WIN_LAST = 12'(HOUR_S - 1);
   localparam logic [3:0] UPD_MAX = 4'(MAX_UPDATES);

   generate
      if (SEC_CYCLES < 2)
      begin : g_bad
         $error("SEC_CYCLES must be at least 2");
      end
   endgenerate

   // Bus slave state
   logic aw_full_r, aw_full_nxt, w_full_r, w_full_nxt;
   logic [31:0] awaddr_r, awaddr_nxt, wdata_r, wdata_nxt;
   logic [3:0] wstrb_r, wstrb_nxt;
   logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
   logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic wr_go, ar_fire, wr_hit, rd_hit;
   logic [15:0] wr_idx, rd_idx, rd_val;

   // Clock state
   logic [DIV_W-1:0] div_r, div_nxt;
   logic [31:0] cnt_r, cnt_nxt, alm_r, alm_nxt, per_mask;
   rtcev_evt_t stat_r, stat_nxt, mask_r, mask_nxt, clr;
   rtcev_ctrl_t ctrl_r, ctrl_nxt;
   logic [15:0] tag_r, tag_nxt, tag_new, scratch_r, scratch_nxt;
   logic keep_r, keep_nxt, busy_r, busy_nxt, irq_r, irq_nxt;
   logic match_q_r, match_q_nxt, match;
   logic [11:0] win_r, win_nxt;
   logic [3:0] upd_r, upd_nxt;
   logic bkup_m_r, bkup_s_r;
   logic run, sec_tick, per_pulse, alm_pulse, time_wr, upd_acc;

   function automatic logic [15:0] merge16(input logic [15:0] old,
      input logic [31:0] d, input logic [3:0] s);
      merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
   endfunction

   assign s_axi_awready = clk_en && !aw_full_r && !bvalid_r;
   assign s_axi_wready = clk_en && !w_full_r && !bvalid_r;
   assign s_axi_arready = clk_en && !rvalid_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rresp = rresp_r;
   assign s_axi_rdata = rdata_r;
   assign rtc_irq = irq_r;
   assign evt_flags = stat_r;

   assign wr_go = clk_en && aw_full_r && w_full_r && !bvalid_r;
   assign ar_fire = s_axi_arvalid && s_axi_arready;
   assign wr_idx = awaddr_r[17:2];
   assign rd_idx = s_axi_araddr[17:2];

   function automatic logic idx_ok(input logic [31:0] a);
      logic [15:0] i;
      i = a[17:2];
      idx_ok = (a[31:18] == '0) && (a[1:0] == '0) &&
         (i == IDX_STAT || i == IDX_MASK || i == IDX_TAG ||
          i == IDX_TIME_HI || i == IDX_TIME_LO || i == IDX_ALM_HI ||
          i == IDX_ALM_LO || i == IDX_CTRL || i == IDX_BKUP ||
          i == IDX_SCRATCH);
   endfunction

   assign wr_hit = idx_ok(awaddr_r);
   assign rd_hit = idx_ok(s_axi_araddr);

   // Read value of the addressed register
   always_comb
   begin
      rd_val = '0;
      case (rd_idx)
         IDX_STAT: rd_val[STAT_PER_BIT:STAT_ALM_BIT] = stat_r;
         IDX_MASK: rd_val[STAT_PER_BIT:STAT_ALM_BIT] = mask_r;
         IDX_TAG: rd_val = tag_r;
         IDX_TIME_HI: rd_val = cnt_r[31:16];
         IDX_TIME_LO: rd_val = cnt_r[15:0];
         IDX_ALM_HI: rd_val = alm_r[31:16];
         IDX_ALM_LO: rd_val = alm_r[15:0];
         IDX_CTRL:
         begin
            rd_val[CTRL_VALID_BIT] = ctrl_r.valid;
            rd_val[CTRL_BUSY_BIT] = busy_r;
            rd_val[CTRL_ALMENA_BIT] = ctrl_r.alm_ena;
            rd_val[CTRL_SEL_LSB+:CTRL_SEL_W] = ctrl_r.sel;
         end
         IDX_BKUP: rd_val[BKUP_KEEP_BIT] = keep_r;
         IDX_SCRATCH: rd_val = scratch_r;
         default: rd_val = '0;
      endcase
   end

   // Bus slave next state
   always_comb
   begin
      aw_full_nxt = aw_full_r;
      w_full_nxt = w_full_r;
      awaddr_nxt = awaddr_r;
      wdata_nxt = wdata_r;
      wstrb_nxt = wstrb_r;
      bvalid_nxt = bvalid_r;
      bresp_nxt = bresp_r;
      rvalid_nxt = rvalid_r;
      rresp_nxt = rresp_r;
      rdata_nxt = rdata_r;
      if (clk_en)
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_full_nxt = 1'b1;
            awaddr_nxt = s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_full_nxt = 1'b1;
            wdata_nxt = s_axi_wdata;
            wstrb_nxt = s_axi_wstrb;
         end
         if (wr_go)
         begin
            aw_full_nxt = 1'b0;
            w_full_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt = wr_hit ? RESP_OKAY : RESP_SLVERR;
         end
         else if (bvalid_r && s_axi_bready)
            bvalid_nxt = 1'b0;
         if (ar_fire)
         begin
            rvalid_nxt = 1'b1;
            rresp_nxt = rd_hit ? RESP_OKAY : RESP_SLVERR;
            rdata_nxt = rd_hit ? {16'h0000, rd_val} : 32'h0000_0000;
         end
         else if (rvalid_r && s_axi_rready)
            rvalid_nxt = 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         aw_full_r <= 1'b0;
         w_full_r <= 1'b0;
         awaddr_r <= '0;
         wdata_r <= '0;
         wstrb_r <= '0;
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
         rvalid_r <= 1'b0;
         rresp_r <= RESP_OKAY;
         rdata_r <= '0;
      end
      else
      begin
         aw_full_r <= aw_full_nxt;
         w_full_r <= w_full_nxt;
         awaddr_r <= awaddr_nxt;
         wdata_r <= wdata_nxt;
         wstrb_r <= wstrb_nxt;
         bvalid_r <= bvalid_nxt;
         bresp_r <= bresp_nxt;
         rvalid_r <= rvalid_nxt;
         rresp_r <= rresp_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   rtcev_tag_gen #(
      .W(16),
      .SEED(TAG_SEED),
      .TAPS(TAG_TAPS)
   ) u_tag (
      .core_clk(core_clk),
      .nrst(nrst),
      .clk_en(clk_en),
      .cur_tag(tag_r),
      .tag_new(tag_new)
   );

   // clock stops in backup without keep
   assign run = clk_en && !(bkup_s_r && !keep_r);
   assign sec_tick = run && (div_r == DIV_LAST);
   assign per_mask = ~({32{1'b1}} << ctrl_r.sel);
   assign match = ctrl_r.alm_ena && (cnt_r == alm_r);
   assign alm_pulse = clk_en && match && !match_q_r;
   assign time_wr = wr_go && wr_hit &&
      (wr_idx == IDX_TIME_HI || wr_idx == IDX_TIME_LO);
   assign upd_acc = time_wr && (upd_r < UPD_MAX);

   // Clock state next values
   always_comb
   begin
      div_nxt = div_r;
      cnt_nxt = cnt_r;
      alm_nxt = alm_r;
      stat_nxt = stat_r;
      mask_nxt = mask_r;
      ctrl_nxt = ctrl_r;
      tag_nxt = tag_r;
      scratch_nxt = scratch_r;
      keep_nxt = keep_r;
      busy_nxt = busy_r;
      match_q_nxt = match_q_r;
      win_nxt = win_r;
      upd_nxt = upd_r;
      per_pulse = 1'b0;
      clr = '0;
      if (clk_en)
      begin
         busy_nxt = upd_acc;
         match_q_nxt = match;
         if (run)
            div_nxt = sec_tick ? '0 : div_r + 1'b1;
         if (sec_tick)
         begin
            cnt_nxt = cnt_r + 1'b1;
            per_pulse = (ctrl_r.sel != '0) && ((cnt_nxt & per_mask) == '0);
            if (upd_r != '0)
            begin
               win_nxt = (win_r == WIN_LAST) ? '0 : win_r + 1'b1;
               if (win_r == WIN_LAST)
                  upd_nxt = '0;
            end
         end
         if (upd_acc)
         begin
            upd_nxt = upd_r + 1'b1;
            ctrl_nxt.valid = 1'b1;
            // random tag on each accepted update
            tag_nxt = tag_new;
            if (wr_idx == IDX_TIME_HI)
               cnt_nxt[31:16] = merge16(cnt_r[31:16], wdata_r, wstrb_r);
            else
               cnt_nxt[15:0] = merge16(cnt_r[15:0], wdata_r, wstrb_r);
         end
         if (wr_go && wr_hit)
         begin
            case (wr_idx)
               IDX_STAT:
               begin
                  if (wstrb_r[0])
                     clr = wdata_r[STAT_PER_BIT:STAT_ALM_BIT];
               end
               IDX_MASK:
               begin
                  if (wstrb_r[0])
                     mask_nxt = wdata_r[STAT_PER_BIT:STAT_ALM_BIT];
               end
               IDX_ALM_HI:
                  alm_nxt[31:16] = merge16(alm_r[31:16], wdata_r, wstrb_r);
               IDX_ALM_LO:
                  alm_nxt[15:0] = merge16(alm_r[15:0], wdata_r, wstrb_r);
               IDX_CTRL:
               begin
                  if (wstrb_r[0])
                     ctrl_nxt.sel = wdata_r[CTRL_SEL_LSB+:CTRL_SEL_W];
                  if (wstrb_r[1])
                     ctrl_nxt.alm_ena = wdata_r[CTRL_ALMENA_BIT];
               end
               IDX_BKUP:
               begin
                  if (wstrb_r[0])
                     keep_nxt = wdata_r[BKUP_KEEP_BIT];
               end
               IDX_SCRATCH: scratch_nxt = merge16(scratch_r, wdata_r, wstrb_r);
               default: scratch_nxt = scratch_r;
            endcase
         end
         stat_nxt.per = (stat_r.per && !clr.per) || per_pulse;
         stat_nxt.alm = (stat_r.alm && !clr.alm) || alm_pulse;
         // backup resets only the flags, masks, interval select and alarm enable
         if (bkup_s_r)
         begin
            stat_nxt = '0;
            mask_nxt = {MASK_BIT_RST, MASK_BIT_RST};
            ctrl_nxt.sel = SEL_RST;
            ctrl_nxt.alm_ena = 1'b0;
         end
      end
      irq_nxt = |(stat_nxt & ~mask_nxt);
   end

   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         div_r <= '0;
         cnt_r <= TIME_RST;
         alm_r <= TIME_RST;
         stat_r <= '0;
         mask_r <= {MASK_BIT_RST, MASK_BIT_RST};
         ctrl_r <= '{valid: 1'b0, alm_ena: 1'b0, sel: SEL_RST};
         tag_r <= TAG_RST;
         scratch_r <= SCRATCH_RST;
         keep_r <= KEEP_RST;
         busy_r <= 1'b0;
         irq_r <= 1'b0;
         match_q_r <= 1'b0;
         win_r <= '0;
         upd_r <= '0;
         bkup_m_r <= 1'b0;
         bkup_s_r <= 1'b0;
      end
      else
      begin
         div_r <= div_nxt;
         cnt_r <= cnt_nxt;
         alm_r <= alm_nxt;
         stat_r <= stat_nxt;
         mask_r <= mask_nxt;
         ctrl_r <= ctrl_nxt;
         tag_r <= tag_nxt;
         scratch_r <= scratch_nxt;
         keep_r <= keep_nxt;
         busy_r <= busy_nxt;
         irq_r <= irq_nxt;
         match_q_r <= match_q_nxt;
         win_r <= win_nxt;
         upd_r <= upd_nxt;
         if (clk_en)
         begin
            bkup_m_r <= backup_mode;
            bkup_s_r <= bkup_m_r;
         end
      end
   end

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!nrst);

   sequence s_accepted_update;
      upd_acc ##1 1'b1;
   endsequence

   a_per_sets: assert property (per_pulse && !bkup_s_r |=> stat_r.per)
      else $error("periodic flag not set");
   a_alm_sets: assert property (alm_pulse && !bkup_s_r |=> stat_r.alm)
      else $error("alarm flag not set");
   a_irq_unmasked: assert property (stat_r.per && !mask_r.per |-> rtc_irq)
      else $error("unmasked flag without interrupt");
   a_w1c_clear: assert property (wr_go && wr_hit && wr_idx == IDX_STAT
      && wstrb_r[0] && wdata_r[STAT_PER_BIT] && !per_pulse |=> !stat_r.per)
      else $error("flag not cleared by one");
   a_mask_backup: assert property (clk_en && bkup_s_r |=> mask_r == 2'h3)
      else $error("masks not reset in backup");
   a_sel_zero: assert property (ctrl_r.sel == '0 && !stat_r.per
      |=> !stat_r.per)
      else $error("periodic event while disabled");
   a_tag_new: assert property (s_accepted_update |-> tag_r != $past(tag_r))
      else $error("tag repeated on update");
   a_tag_hold: assert property (!upd_acc |=> tag_r == $past(tag_r))
      else $error("tag changed without update");
   a_upd_limit: assert property (time_wr && upd_r >= UPD_MAX
      |=> tag_r == $past(tag_r) && !busy_r)
      else $error("update taken beyond the hourly limit");
   a_osc_stop: assert property (bkup_s_r && !keep_r |-> !sec_tick)
      else $error("clock runs in backup");
   a_cnt_step: assert property (sec_tick && !upd_acc
      |=> cnt_r == $past(cnt_r) + 32'h0000_0001)
      else $error("counter step wrong");
endmodule

/* rtcev_host.sv */
`timescale 1ns/100ps
module rtcev_host (
   // Clock
   input wire logic core_clk,
   // Write channels
   output logic [31:0] s_axi_awaddr,
   output logic s_axi_awvalid,
   input wire logic s_axi_awready,
   output logic [31:0] s_axi_wdata,
   output logic [3:0] s_axi_wstrb,
   output logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   output logic s_axi_bready,
   // Read channels
   output logic [31:0] s_axi_araddr,
   output logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   output logic s_axi_rready
);
   import rtcev_pkg::*;
   logic [15:0] tag_copy;

   initial
   begin
      s_axi_awaddr = 32'h0000_0000;
      s_axi_awvalid = 1'b0;
      s_axi_wdata = 32'h0000_0000;
      s_axi_wstrb = 4'h0;
      s_axi_wvalid = 1'b0;
      s_axi_bready = 1'b0;
      s_axi_araddr = 32'h0000_0000;
      s_axi_arvalid = 1'b0;
      s_axi_rready = 1'b0;
      tag_copy = TAG_RST;
   end

   task automatic wr(input logic [15:0] idx, input logic [15:0] d,
      output logic [1:0] resp);
      @(posedge core_clk);
      s_axi_awaddr <= {14'h0000, idx, 2'h0};
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= {16'h0000, d};
      s_axi_wstrb <= 4'hf;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge core_clk);
         if (s_axi_awvalid && s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready)
            s_axi_wvalid <= 1'b0;
      end
      while (!s_axi_bvalid);
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask

   task automatic rd(input logic [15:0] idx, output logic [15:0] d,
      output logic [1:0] resp);
      @(posedge core_clk);
      s_axi_araddr <= {14'h0000, idx, 2'h0};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(posedge core_clk);
         if (s_axi_arvalid && s_axi_arready)
            s_axi_arvalid <= 1'b0;
      end
      while (!s_axi_rvalid);
      d = s_axi_rdata[15:0];
      resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask

   task automatic set_time(input logic [15:0] idx, input logic [15:0] v,
      output logic [15:0] tag);
      logic [15:0] c;
      logic [1:0] r;
      c = 16'h4000;
      while (c[CTRL_BUSY_BIT])
         rd(IDX_CTRL, c, r);
      wr(idx, v, r);
      rd(IDX_TAG, tag, r);
      tag_copy = tag;
   endtask

   task automatic tampered(output logic t);
      logic [15:0] v;
      logic [1:0] r;
      rd(IDX_TAG, v, r);
      t = (v != tag_copy);
   endtask
endmodule

/* rtc_events_and_write_guard_tb.sv */
`timescale 1ns/100ps
`define CHK(g, e) \
   begin \
      tests_run++; \
      if ((g) !== (e)) \
      begin \
         $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); \
         err_count++; \
      end \
   end
module rtc_events_and_write_guard_tb;
   import rtcev_pkg::*;
   localparam int SEC = 8;
   int err_count;
   int tests_run;
   logic core_clk, nrst, clk_en, backup_mode, rtc_irq;
   rtcev_evt_t evt_flags;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready;

   rtcev_core #(.SEC_CYCLES(SEC)) uut (.core_clk, .nrst, .clk_en,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .backup_mode, .rtc_irq, .evt_flags);

   rtcev_host h (.core_clk, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

   initial
   begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end

   task automatic test_done();
      $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic wait_flag(input logic alm, input int lim);
      for (int n = 0; n < lim; n++)
      begin
         @(negedge core_clk);
         if (alm ? evt_flags.alm : evt_flags.per)
            break;
      end
   endtask

   task automatic t_reset();
      logic [15:0] d;
      logic [1:0] r;
      h.rd(IDX_MASK, d, r);
      `CHK(d[3:2], 2'h3)
      h.rd(IDX_CTRL, d, r);
      `CHK(d[6:4], 3'h0)
      h.rd(IDX_TAG, d, r);
      `CHK(d, TAG_RST)
      `CHK({rtc_irq, evt_flags}, 3'h0)
      h.rd(16'h4000, d, r);
      `CHK(r, RESP_SLVERR)
      h.wr(16'h4000, 16'h0001, r);
      `CHK(r, RESP_SLVERR)
   endtask

   task automatic t_alarm();
      logic [15:0] t;
      logic [1:0] r;
      h.rd(IDX_TIME_LO, t, r);
      h.wr(IDX_ALM_HI, 16'h0000, r);
      h.wr(IDX_ALM_LO, t + 16'h0006, r);
      h.wr(IDX_CTRL, 16'h0400, r);
      wait_flag(1'b1, SEC * 12);
      `CHK(evt_flags, 2'h1)
      `CHK(rtc_irq, 1'b0)
      h.rd(IDX_STAT, t, r);
      `CHK(t[3:2], 2'h1)
      h.wr(IDX_MASK, 16'h0008, r);
      repeat (2) @(negedge core_clk);
      `CHK(rtc_irq, 1'b1)
      h.wr(IDX_STAT, 16'h0000, r);
      repeat (2) @(negedge core_clk);
      `CHK(evt_flags.alm, 1'b1)
      h.wr(IDX_STAT, 16'h0004, r);
      repeat (2) @(negedge core_clk);
      `CHK({rtc_irq, evt_flags.alm}, 2'h0)
      h.wr(IDX_CTRL, 16'h0000, r);
   endtask

   task automatic t_periodic();
      logic [15:0] d;
      logic [1:0] r;
      h.wr(IDX_MASK, 16'h0004, r);
      for (int c = 1; c < 8; c++)
      begin
         h.wr(IDX_CTRL, {9'h000, c[2:0], 4'h0}, r);
         h.wr(IDX_STAT, 16'h0008, r);
         wait_flag(1'b0, SEC * (2 << c) + 40);
         h.rd(IDX_TIME_LO, d, r);
         `CHK(evt_flags.per & rtc_irq, 1'b1)
         `CHK(d & ((16'h0001 << c) - 16'h0001), 16'h0000)
      end
      h.rd(IDX_CTRL, d, r);
      `CHK(d[6:4], 3'h7)
      h.wr(IDX_CTRL, 16'h0000, r);
      h.wr(IDX_STAT, 16'h0008, r);
      repeat (SEC * 4) @(negedge core_clk);
      `CHK(evt_flags.per, 1'b0)
   endtask

   task automatic t_backup();
      logic [15:0] a;
      logic [15:0] b;
      logic [1:0] r;
      h.wr(IDX_SCRATCH, 16'h5a5a, r);
      h.wr(IDX_CTRL, 16'h0010, r);
      wait_flag(1'b0, SEC * 4);
      `CHK(evt_flags.per, 1'b1)
      @(posedge core_clk);
      backup_mode <= 1'b1;
      repeat (4) @(negedge core_clk);
      `CHK({rtc_irq, evt_flags}, 3'h0)
      h.rd(IDX_MASK, a, r);
      `CHK(a[3:2], 2'h3)
      h.rd(IDX_SCRATCH, a, r);
      `CHK(a, 16'h5a5a)
      h.rd(IDX_TIME_LO, a, r);
      repeat (SEC * 3) @(negedge core_clk);
      h.rd(IDX_TIME_LO, b, r);
      `CHK(b - a > 16'h0001, 1'b1)
      h.wr(IDX_BKUP, 16'h0000, r);
      h.rd(IDX_TIME_LO, a, r);
      repeat (SEC * 3) @(negedge core_clk);
      h.rd(IDX_TIME_LO, b, r);
      `CHK(b, a)
      @(posedge core_clk);
      backup_mode <= 1'b0;
      h.wr(IDX_BKUP, 16'h0001, r);
   endtask

   task automatic t_tag();
      logic [15:0] prev;
      logic [15:0] tag;
      logic [1:0] r;
      logic bad;
      prev = TAG_RST;
      for (int i = 0; i < MAX_UPDATES; i++)
      begin
         h.set_time(i == 0 ? IDX_TIME_HI : IDX_TIME_LO, 16'h1000 + i[15:0],
            tag);
         `CHK(tag != prev, 1'b1)
         prev = tag;
      end
      h.tampered(bad);
      `CHK(bad, 1'b0)
      h.wr(IDX_TAG, 16'h1234, r);
      h.rd(IDX_TAG, tag, r);
      `CHK(tag, prev)
      h.wr(IDX_TIME_LO, 16'hbeef, r);
      h.rd(IDX_TAG, tag, r);
      `CHK(tag, prev)
      h.rd(IDX_TIME_LO, tag, r);
      `CHK(tag[15:12], 4'h1)
      h.rd(IDX_TIME_HI, tag, r);
      `CHK(tag, 16'h1000)
   endtask

   task automatic t_freeze();
      logic [15:0] a;
      logic [15:0] b;
      logic [1:0] r;
      h.rd(IDX_TIME_LO, a, r);
      @(posedge core_clk);
      clk_en <= 1'b0;
      repeat (SEC * 3) @(negedge core_clk);
      `CHK({s_axi_awready, s_axi_wready, s_axi_arready}, 3'h0)
      @(posedge core_clk);
      clk_en <= 1'b1;
      h.rd(IDX_TIME_LO, b, r);
      `CHK(b - a < 16'h0002, 1'b1)
   endtask

   initial
   begin
      repeat (20000) @(posedge core_clk);
      err_count++;
      test_done();
   end

   initial
   begin
      err_count = 0;
      tests_run = 0;
      nrst = 1'b0;
      clk_en = 1'b1;
      backup_mode = 1'b0;
      repeat (6) @(posedge core_clk);
      nrst <= 1'b1;
      t_reset();
      t_alarm();
      t_periodic();
      t_backup();
      t_freeze();
      t_tag();
      test_done();
   end
endmodule
